// ===== logic/cycle_sched_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// shared constants and types for the work cycle scheduler
package cycle_sched_pkg;

	// widths of calendar and length inputs
	localparam int TOD_W = 17;
	localparam int LEN_W = 22;
	localparam int DAYN_W = 16;
	localparam int DOM_W = 5;
	localparam int SLOTS = 24;
	localparam int TRIGS = 4;

	// fixed phase lengths, in seconds
	localparam logic [LEN_W-1:0] PRESTANDBY_S = 22'h000078;
	localparam logic [LEN_W-1:0] WARMING_S = 22'h00003c;
	localparam logic [LEN_W-1:0] FIRST_ZERO_S = 22'h00003c;

	// adjustable period limits, in days
	localparam logic [DOM_W-1:0] PERIOD_MIN = 5'h01;
	localparam logic [DOM_W-1:0] PERIOD_MAX = 5'h1e;

	// reset values and the one-second counter step
	localparam logic [TRIGS-1:0] TRIG_IDLE = 4'hf;
	localparam logic [LEN_W-1:0] LEN_ZERO = 22'h000000;
	localparam logic [LEN_W-1:0] LEN_ONE = 22'h000001;
	localparam logic [DAYN_W-1:0] DAYN_ZERO = 16'h0000;

	// work modes
	typedef enum logic [1:0] {
		MODE_SCHEDULER = 2'h0,
		MODE_TRIGGERED = 2'h1,
		MODE_MONTHLY = 2'h2,
		MODE_ADJUSTABLE = 2'h3
	} work_mode_t;

	// work phases
	typedef enum logic [2:0] {
		PH_WARMING = 3'h0,
		PH_FIRST_ZERO = 3'h1,
		PH_VENTILATION = 3'h2,
		PH_MEASUREMENT = 3'h3,
		PH_PRESTANDBY = 3'h4,
		PH_STANDBY = 3'h5
	} phase_t;

endpackage

// ===== logic/work_mode_cycle_scheduler.sv
`timescale 1ns/100ps
module work_mode_cycle_scheduler
	import cycle_sched_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire work_mode_t work_mode,
	input wire logic second_tick,
	input wire logic [TOD_W-1:0] time_of_day,
	input wire logic [DOM_W-1:0] day_of_month,
	input wire logic [DOM_W-1:0] days_in_month,
	input wire logic [DAYN_W-1:0] day_number,
	input wire logic [SLOTS-1:0] slot_enable,
	input wire logic [SLOTS-1:0][TOD_W-1:0] slot_time,
	input wire logic [TRIGS-1:0] trigger_input,
	input wire logic [TRIGS-1:0] trigger_enable,
	input wire logic [LEN_W-1:0] ventilation_length,
	input wire logic [LEN_W-1:0] measurement_length,
	input wire logic [LEN_W-1:0] cycle_length,
	input wire logic [DOM_W-1:0] zero_day,
	input wire logic [TOD_W-1:0] zero_time,
	input wire logic [DAYN_W-1:0] first_zero_day,
	input wire logic [DOM_W-1:0] period_days,
	output phase_t phase,
	output logic cycle_start,
	output logic init_done
);

	phase_t phase_reg;
	phase_t phase_next;
	logic cycle_start_reg;
	logic init_done_reg;
	logic [TRIGS-1:0] trig_meta_reg;
	logic [TRIGS-1:0] trig_sync_reg;
	logic [TRIGS-1:0] trig_prev_reg;
	logic [TRIGS-1:0] trig_rise;
	logic [LEN_W-1:0] phase_secs_reg;
	logic [LEN_W-1:0] cycle_secs_reg;
	logic [LEN_W-1:0] phase_secs_inc;
	logic [LEN_W-1:0] cycle_secs_inc;
	logic [DAYN_W-1:0] next_zero_reg;
	logic zero_loaded_reg;
	logic [DOM_W-1:0] eff_zero_day;
	logic [DOM_W-1:0] period_eff;
	logic slot_hit;
	logic zero_time_hit;
	logic monthly_hit;
	logic adjust_hit;
	logic start_evt;
	logic accept;
	logic long_mode;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////////////////////////////////////////
	// trigger inputs

	// two-flop synchroniser then edge memory; idle value high
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			trig_meta_reg <= TRIG_IDLE;
			trig_sync_reg <= TRIG_IDLE;
			trig_prev_reg <= TRIG_IDLE;
		end else begin
			trig_meta_reg <= trigger_input;
			trig_sync_reg <= trig_meta_reg;
			trig_prev_reg <= trig_sync_reg;
		end
	end

	// rising edges on enabled inputs only
	assign trig_rise = trig_sync_reg & ~trig_prev_reg & trigger_enable;

	////////////////////////////////////////////////////////////////////////////
	// start moments

	// any enabled daily slot matching the current second
	always_comb begin
		slot_hit = 1'b0;
		for (int i = 0; i < SLOTS; i++) begin
			if (slot_enable[i] && slot_time[i] == time_of_day) begin
				slot_hit = 1'b1;
			end
		end
	end

	// zeroing day clamped to the month's last day
	assign eff_zero_day = (zero_day > days_in_month) ? days_in_month : zero_day;

	// period limited to one to thirty days
	always_comb begin
		if (period_days < PERIOD_MIN) begin
			period_eff = PERIOD_MIN;
		end else if (period_days > PERIOD_MAX) begin
			period_eff = PERIOD_MAX;
		end else begin
			period_eff = period_days;
		end
	end

	assign zero_time_hit = second_tick && (time_of_day == zero_time);
	assign monthly_hit = zero_time_hit && (day_of_month == eff_zero_day);
	assign adjust_hit = zero_time_hit && zero_loaded_reg && (day_number == next_zero_reg);
	assign long_mode = (work_mode == MODE_MONTHLY) || (work_mode == MODE_ADJUSTABLE);

	// start event for the selected mode
	always_comb begin
		case (work_mode)
			MODE_SCHEDULER: start_evt = second_tick && slot_hit;
			MODE_TRIGGERED: start_evt = |trig_rise;
			MODE_MONTHLY: start_evt = monthly_hit;
			MODE_ADJUSTABLE: start_evt = adjust_hit;
			default: start_evt = 1'b0;
		endcase
	end

	// a start preempts any phase once initial phases are over
	assign accept = start_evt && init_done_reg;

	////////////////////////////////////////////////////////////////////////////
	// adjustable period: next zeroing day

	// load first date after reset, catch up, then step per zeroing
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			next_zero_reg <= DAYN_ZERO;
			zero_loaded_reg <= 1'b0;
		end else if (!zero_loaded_reg) begin
			next_zero_reg <= first_zero_day;
			zero_loaded_reg <= 1'b1;
		end else if (next_zero_reg < day_number) begin
			next_zero_reg <= next_zero_reg + DAYN_W'(period_eff);
		end else if (adjust_hit) begin
			next_zero_reg <= next_zero_reg + DAYN_W'(period_eff);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// phase sequencing

	assign phase_secs_inc = phase_secs_reg + LEN_ONE;
	assign cycle_secs_inc = cycle_secs_reg + LEN_ONE;

	// next phase; midnight plays no part here
	always_comb begin
		phase_next = phase_reg;
		if (accept) begin
			phase_next = PH_VENTILATION;
		end else if (second_tick) begin
			case (phase_reg)
				PH_WARMING: begin
					if (phase_secs_inc >= WARMING_S) begin
						phase_next = PH_FIRST_ZERO;
					end
				end
				PH_FIRST_ZERO: begin
					if (phase_secs_inc >= FIRST_ZERO_S) begin
						phase_next = PH_MEASUREMENT;
					end
				end
				PH_VENTILATION: begin
					if (phase_secs_inc >= ventilation_length) begin
						phase_next = PH_MEASUREMENT;
					end
				end
				PH_MEASUREMENT: begin
					if (!long_mode && (phase_secs_inc >= measurement_length ||
						(cycle_length != LEN_ZERO && cycle_secs_inc >= cycle_length))) begin
						phase_next = PH_PRESTANDBY;
					end
				end
				PH_PRESTANDBY: begin
					if (phase_secs_inc >= PRESTANDBY_S) begin
						phase_next = PH_STANDBY;
					end
				end
				PH_STANDBY: phase_next = PH_STANDBY;
				default: phase_next = PH_STANDBY;
			endcase
		end
	end

	// phase register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase_reg <= PH_WARMING;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// seconds spent in the current phase
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase_secs_reg <= LEN_ZERO;
		end else if (accept || phase_next != phase_reg) begin
			phase_secs_reg <= LEN_ZERO;
		end else if (second_tick) begin
			phase_secs_reg <= phase_secs_inc;
		end
	end

	// seconds since the cycle began
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cycle_secs_reg <= LEN_ZERO;
		end else if (accept) begin
			cycle_secs_reg <= LEN_ZERO;
		end else if (second_tick) begin
			cycle_secs_reg <= cycle_secs_inc;
		end
	end

	// start pulse and initial-phase status
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cycle_start_reg <= 1'b0;
			init_done_reg <= 1'b0;
		end else begin
			cycle_start_reg <= accept;
			init_done_reg <= (phase_next != PH_WARMING) && (phase_next != PH_FIRST_ZERO);
		end
	end

	assign phase = phase_reg;
	assign cycle_start = cycle_start_reg;
	assign init_done = init_done_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence enabled_rise_s;
		work_mode == MODE_TRIGGERED && init_done_reg && (|trig_rise);
	endsequence

	sequence new_cycle_s;
		cycle_start_reg && phase_reg == PH_VENTILATION;
	endsequence

	sequence prestandby_end_s;
		phase_reg == PH_PRESTANDBY && second_tick && !accept &&
			phase_secs_reg == PRESTANDBY_S - LEN_ONE;
	endsequence

	prestandby_length_a: assert property (prestandby_end_s |=> phase_reg == PH_STANDBY)
		else $error("prestandby did not end after two minutes");

	prestandby_early_a: assert property (
		phase_reg == PH_PRESTANDBY && !accept && phase_secs_reg < PRESTANDBY_S - LEN_ONE
		|=> phase_reg == PH_PRESTANDBY)
		else $error("prestandby left early");

	midnight_no_abort_a: assert property (
		time_of_day == '0 && phase_reg == PH_MEASUREMENT && !accept && !second_tick
		|=> phase_reg == PH_MEASUREMENT)
		else $error("measurement left without a start or tick");

	slot_start_a: assert property (
		work_mode == MODE_SCHEDULER && init_done_reg && second_tick && slot_hit
		|=> new_cycle_s)
		else $error("enabled slot did not start a cycle");

	trigger_start_a: assert property (enabled_rise_s |=> new_cycle_s)
		else $error("enabled trigger edge did not restart the cycle");

	disabled_trig_a: assert property (
		work_mode == MODE_TRIGGERED && trig_rise == '0 |=> !cycle_start_reg)
		else $error("cycle started without an enabled edge");

	// first pin sample high after low; the edge needs one more flop
	sequence pin_rise_s;
		work_mode == MODE_TRIGGERED && init_done_reg && trigger_enable[0] && !trig_meta_reg[0]
		##1 trig_meta_reg[0] && $stable(work_mode) && $stable(trigger_enable) &&
		init_done_reg;
	endsequence

	pin_to_start_a: assert property (
		pin_rise_s |=> ##1 cycle_start_reg)
		else $error("trigger edge not taken two samples later");

	standby_hold_a: assert property (
		phase_reg == PH_STANDBY && !accept |=> phase_reg == PH_STANDBY)
		else $error("standby left without a start");

	init_order_a: assert property (
		phase_reg == PH_WARMING && !(second_tick && phase_secs_inc >= WARMING_S)
		|=> phase_reg == PH_WARMING)
		else $error("warming ended early");

	monthly_meas_a: assert property (
		long_mode && phase_reg == PH_MEASUREMENT && !accept |=> phase_reg == PH_MEASUREMENT)
		else $error("long mode measurement ended without zeroing");

	month_end_a: assert property (
		work_mode == MODE_MONTHLY && init_done_reg && zero_time_hit &&
		zero_day > days_in_month && day_of_month == days_in_month |=> new_cycle_s)
		else $error("short month zeroing missed on last day");

	adjust_step_a: assert property (
		zero_loaded_reg && adjust_hit && next_zero_reg >= day_number |=>
		next_zero_reg == $past(next_zero_reg) + DAYN_W'($past(period_eff)))
		else $error("next zeroing day not advanced by the period");

	vent_end_a: assert property (
		phase_reg == PH_VENTILATION && second_tick && !accept &&
		phase_secs_inc >= ventilation_length |=> phase_reg == PH_MEASUREMENT)
		else $error("ventilation did not end at its length");

	meas_end_a: assert property (
		!long_mode && phase_reg == PH_MEASUREMENT && second_tick && !accept &&
		phase_secs_inc >= measurement_length |=> phase_reg == PH_PRESTANDBY)
		else $error("measurement did not end at its length");

	cycle_cap_a: assert property (
		!long_mode && phase_reg == PH_MEASUREMENT && second_tick && !accept &&
		cycle_length != LEN_ZERO && cycle_secs_inc >= cycle_length
		|=> phase_reg == PH_PRESTANDBY)
		else $error("cycle length did not end measurement");

	init_refuse_a: assert property (!init_done_reg |=> !cycle_start_reg)
		else $error("cycle started during warming or first zeroing");

	init_done_keep_a: assert property (init_done_reg |=> init_done_reg)
		else $error("initial phases came back after they ended");

	first_zero_end_a: assert property (
		phase_reg == PH_FIRST_ZERO && second_tick && phase_secs_inc >= FIRST_ZERO_S
		|=> phase_reg == PH_MEASUREMENT && init_done_reg)
		else $error("first zeroing did not lead to measurement");

	monthly_start_a: assert property (
		work_mode == MODE_MONTHLY && init_done_reg && monthly_hit |=> new_cycle_s)
		else $error("monthly zeroing did not start a cycle");

	adjust_start_a: assert property (
		work_mode == MODE_ADJUSTABLE && init_done_reg && adjust_hit |=> new_cycle_s)
		else $error("periodic zeroing did not start a cycle");

endmodule // work_mode_cycle_scheduler

// ===== tb/tb_work_mode_cycle_scheduler.sv
`timescale 1ns/100ps
module tb_work_mode_cycle_scheduler
	import cycle_sched_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	work_mode_t work_mode = MODE_TRIGGERED;
	logic second_tick = 1'b0;
	logic [TOD_W-1:0] time_of_day = 17'h00001;
	logic [DOM_W-1:0] day_of_month = 5'h01;
	logic [DOM_W-1:0] days_in_month = 5'h1c;
	logic [DAYN_W-1:0] day_number = 16'h0060;
	logic [SLOTS-1:0] slot_enable = 24'h000002;
	logic [SLOTS-1:0][TOD_W-1:0] slot_time = '0;
	logic [TRIGS-1:0] trigger_input;
	logic [TRIGS-1:0] trigger_enable = 4'h5;
	logic [TRIGS-1:0] pulse_req = 4'h0;
	logic [LEN_W-1:0] cycle_length = 22'h000000;
	logic [DOM_W-1:0] period_days = 5'h07;
	phase_t phase;
	logic cycle_start;
	logic init_done;
	logic [31:0] errors = 32'h0;
	logic [31:0] comparisons = 32'h0;
	logic [31:0] starts = 32'h0;
	logic [31:0] base;

	work_mode_cycle_scheduler work_mode_cycle_scheduler_i (.ref_clk(ref_clk), .reset(reset),
		.work_mode(work_mode), .second_tick(second_tick), .time_of_day(time_of_day),
		.day_of_month(day_of_month), .days_in_month(days_in_month), .day_number(day_number),
		.slot_enable(slot_enable), .slot_time(slot_time), .trigger_input(trigger_input),
		.trigger_enable(trigger_enable), .ventilation_length(22'h000003),
		.measurement_length(22'h000005), .cycle_length(cycle_length), .zero_day(5'h1f),
		.zero_time(17'h0012c), .first_zero_day(16'h0064), .period_days(period_days),
		.phase(phase), .cycle_start(cycle_start), .init_done(init_done));

	trigger_source trigger_source_i (.ref_clk(ref_clk), .pulse_req(pulse_req),
		.trigger_input(trigger_input));

	// 125 MHz clock
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	// count cycle start pulses
	always @(posedge ref_clk) begin
		if (cycle_start === 1'b1) starts <= starts + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// access tasks
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons = comparisons + 32'h1;
		if (exp !== got) begin
			errors = errors + 32'h1;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			second_tick <= 1'b1;
			@(posedge ref_clk);
			second_tick <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask

	task automatic tick_at(input logic [TOD_W-1:0] tod);
		time_of_day <= tod;
		@(posedge ref_clk);
		tick(1);
		time_of_day <= 17'h00001;
	endtask

	task automatic fire(input logic [TRIGS-1:0] mask);
		pulse_req <= mask;
		@(posedge ref_clk);
		pulse_req <= 4'h0;
		repeat (14) @(posedge ref_clk);
	endtask

	task automatic starts_is(input logic [31:0] n);
		check("starts", base + n, starts);
		base = starts;
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 32'h0 && comparisons != 32'h0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		slot_time[0] = 17'h00064;
		slot_time[1] = 17'h000c8;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		base = starts;
		check("phase", PH_WARMING, phase);
		check("init", 1'b0, init_done);
		fire(4'h1);
		tick(59);
		check("phase", PH_WARMING, phase);
		tick(1);
		check("phase", PH_FIRST_ZERO, phase);
		tick(60);
		check("phase", PH_MEASUREMENT, phase);
		check("init", 1'b1, init_done);
		starts_is(0);
		tick(4);
		check("phase", PH_MEASUREMENT, phase);
		tick(1);
		check("phase", PH_PRESTANDBY, phase);
		tick(119);
		check("phase", PH_PRESTANDBY, phase);
		tick(1);
		check("phase", PH_STANDBY, phase);
		tick_at(17'h00000);
		check("phase", PH_STANDBY, phase);
		fire(4'ha);
		starts_is(0);
		fire(4'h1);
		starts_is(1);
		check("phase", PH_VENTILATION, phase);
		tick(2);
		check("phase", PH_VENTILATION, phase);
		tick(1);
		check("phase", PH_MEASUREMENT, phase);
		tick_at(17'h00000);
		check("phase", PH_MEASUREMENT, phase);
		fire(4'h4);
		starts_is(1);
		check("phase", PH_VENTILATION, phase);
		// cycle length cuts measurement short
		cycle_length <= 22'h000006;
		tick(5);
		check("phase", PH_MEASUREMENT, phase);
		tick(1);
		check("phase", PH_PRESTANDBY, phase);
		cycle_length <= 22'h000000;
		// daily slots: slot 0 disabled, slot 1 enabled
		work_mode <= MODE_SCHEDULER;
		tick_at(17'h00000);
		starts_is(0);
		tick_at(17'h00064);
		starts_is(0);
		tick_at(17'h000c8);
		starts_is(1);
		check("phase", PH_VENTILATION, phase);
		// monthly zeroing clipped to a short month
		work_mode <= MODE_MONTHLY;
		day_of_month <= 5'h1b;
		tick_at(17'h0012c);
		starts_is(0);
		day_of_month <= 5'h1c;
		tick_at(17'h0012c);
		starts_is(1);
		tick(130);
		check("phase", PH_MEASUREMENT, phase);
		starts_is(0);
		// adjustable period of seven days from day 100
		work_mode <= MODE_ADJUSTABLE;
		day_number <= 16'h0067;
		tick_at(17'h0012c);
		starts_is(0);
		day_number <= 16'h006b;
		tick_at(17'h0012c);
		starts_is(1);
		day_number <= 16'h006e;
		tick_at(17'h0012c);
		starts_is(0);
		day_number <= 16'h0072;
		tick_at(17'h0012c);
		starts_is(1);
		// a zero period acts as one day
		period_days <= 5'h00;
		day_number <= 16'h0079;
		tick_at(17'h0012c);
		starts_is(1);
		day_number <= 16'h007a;
		tick_at(17'h0012c);
		starts_is(1);
		give_verdict();
	end

	// watchdog well beyond the expected run
	initial begin
		repeat (40000) @(posedge ref_clk);
		errors = errors + 32'h1;
		give_verdict();
	end
endmodule // tb_work_mode_cycle_scheduler

// ===== tb/trigger_source.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// external equipment on the four trigger lines
module trigger_source
	import cycle_sched_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [TRIGS-1:0] pulse_req,
	output logic [TRIGS-1:0] trigger_input
);
	logic [TRIGS-1:0] low_reg = 4'h0;
	logic [2:0] hold_reg = 3'h0;

	// pull requested lines low a few cycles, then let them go
	always @(posedge ref_clk) begin
		if (pulse_req != 4'h0) begin
			low_reg <= pulse_req;
			hold_reg <= 3'h4;
		end else if (hold_reg != 3'h0) begin
			hold_reg <= hold_reg - 3'h1;
		end else begin
			low_reg <= 4'h0; // release gives the rising edge
		end
	end

	// released or unconnected lines float high
	assign trigger_input = ~low_reg;
endmodule // trigger_source
